/* rtl/vpc_pkg.sv */
// Purpose: Shared constants for the video processing control register bank
// Assumes: 16-bit host serial words, 12-bit register addresses
// Notes: Register offsets are word addresses on the host serial port
package vpc_pkg;
    // ------------------------------------------------------------------
    // Host serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;
    localparam int CMD_RW_BIT = 15;
    localparam int CMD_AUTOINC_BIT = 12;
    localparam logic [3:0] LAST_BIT_CNT = 4'hf;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_IO_PROC_ONE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_IO_PROC_TWO = 12'h001;
    // ------------------------------------------------------------------
    // io_processing_control_one fields
    // ------------------------------------------------------------------
    localparam int B1_TIMING_WORD_REMAP_OFF_S1 = 14;
    localparam int B1_ERR_FLAG_UPDATE_OFF = 12;
    localparam int B1_ERR_CHECK_INSERT_OFF = 11;
    localparam int B1_H_BLANK_STYLE = 10;
    localparam int B1_AUX_EXTRACT_OFF = 9;
    localparam int B1_TIMING_PIN_OVERRIDE = 7;
    localparam int B1_TIMING_FORMAT = 6;
    localparam int B1_BAD_WORD_REMAP_OFF_S1 = 4;
    localparam int B1_AUX_SUM_INSERT_OFF_S1 = 3;
    localparam int B1_LINE_CHECK_INSERT_OFF_S1 = 2;
    localparam int B1_LINE_NUMBER_INSERT_OFF_S1 = 1;
    localparam int B1_TIMING_WORD_INSERT_OFF_S1 = 0;
    // ------------------------------------------------------------------
    // io_processing_control_two fields
    // ------------------------------------------------------------------
    localparam int B2_TIMING_WORD_REMAP_OFF_S2 = 12;
    localparam int B2_PAYLOAD_ID_REGEN_OFF = 10;
    localparam int B2_STREAM_SWAP = 9;
    localparam int B2_LEVEL_CONVERT_OFF = 8;
    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0] MASK_IO_PROC_ONE = 16'h5edf;
    localparam logic [WORD_W-1:0] MASK_IO_PROC_TWO = 16'h1700;
    localparam logic [WORD_W-1:0] RST_IO_PROC_ONE = 16'h0000;
    localparam logic [WORD_W-1:0] RST_IO_PROC_TWO = 16'h0100;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        VPC_HP_IDLE,
        VPC_HP_CMD,
        VPC_HP_WDATA,
        VPC_HP_RDATA
    } vpc_host_state_e;
endpackage

/* rtl/vpc_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clk
// Notes: Only the second stage may be read by logic
`timescale 1ns/10ps
module vpc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) begin
            $error("vpc_sync: W must be at least 1");
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            meta_reg <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule

/* rtl/vpc_out_mux.sv */
// Purpose: Places the two data streams on the parallel output
// Assumes: Stream words arrive on i_clk, one pair per cycle
// Notes: In DDR mode one word leaves per cycle, alternating order
`timescale 1ns/10ps
module vpc_out_mux #(
    parameter int SW = 10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [SW-1:0] i_s1,
    input wire logic [SW-1:0] i_s2,
    input wire logic i_swap,
    input wire logic i_ddr_mode,
    output logic [2*SW-1:0] o_dout,
    output logic o_second_word
);
    logic phase_reg;

    initial begin
        if (SW < 1) begin
            $error("vpc_out_mux: SW must be at least 1");
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= i_ddr_mode ? ~phase_reg : 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_dout <= '0;
            o_second_word <= 1'b0;
        end else if (!i_ddr_mode) begin
            o_dout <= i_swap ? {i_s2, i_s1} : {i_s1, i_s2};
            o_second_word <= 1'b0;
        end else begin
            // Phase 0 carries the leading stream
            if (!phase_reg) begin
                o_dout <= {{SW{1'b0}}, (i_swap ? i_s1 : i_s2)};
            end else begin
                o_dout <= {{SW{1'b0}}, (i_swap ? i_s2 : i_s1)};
            end
            o_second_word <= phase_reg;
        end
    end
endmodule

/* rtl/vpc_ctrl_regs.sv */
// Purpose: Video output processing control registers behind the host serial port
// Assumes: Host serial pins are slow against the 10 MHz core clock
// Notes: Registers hold control only; the video engines read the enables
`timescale 1ns/10ps
module vpc_ctrl_regs #(
    parameter int SW = 10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    // Host serial port pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdin,
    output logic o_sdout,
    output logic o_sdout_oe_n,
    // Timing format select pin
    input wire logic i_timing_format_pin,
    // Video side, on i_clk
    input wire logic i_level_b,
    input wire logic i_line_blank,
    input wire logic i_trs_h_flag,
    input wire logic i_hsync_861,
    input wire logic i_ddr_mode,
    input wire logic [SW-1:0] i_stream_one,
    input wire logic [SW-1:0] i_stream_two,
    output logic o_h,
    output logic o_timing_861,
    output logic o_err_flag_update_en,
    output logic o_err_check_insert_en,
    output logic o_aux_extract_en,
    output logic o_timing_word_remap_en_s1,
    output logic o_timing_word_remap_en_s2,
    output logic o_bad_word_remap_en_s1,
    output logic o_aux_sum_insert_en_s1,
    output logic o_line_check_insert_en_s1,
    output logic o_line_number_insert_en_s1,
    output logic o_timing_word_insert_en_s1,
    output logic o_payload_id_regen_en,
    output logic o_level_convert_en,
    output logic [2*SW-1:0] o_dout,
    output logic o_second_word
);
    import vpc_pkg::*;

    initial begin
        if (SW != 10) begin
            $error("vpc_ctrl_regs: streams are 10 bits wide");
        end
    end

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [WORD_W-1:0] reg_mask(input logic [ADDR_W-1:0] a);
        logic [WORD_W-1:0] m;
        m = WORD_ZERO;
        if (a == ADDR_IO_PROC_ONE) begin
            m = MASK_IO_PROC_ONE;
        end else if (a == ADDR_IO_PROC_TWO) begin
            m = MASK_IO_PROC_TWO;
        end
        return m;
    endfunction

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        return ADDR_W'(a + 1'b1);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pins_sync;
    logic cs_n_s;
    logic sclk_s;
    logic sdin_s;
    logic fmt_pin_s;

    vpc_sync #(
        .W(4),
        .RST_VAL(4'h8)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_cs_n, i_sclk, i_sdin, i_timing_format_pin}),
        .o_q(pins_sync)
    );

    assign cs_n_s = pins_sync[3];
    assign sclk_s = pins_sync[2];
    assign sdin_s = pins_sync[1];
    assign fmt_pin_s = pins_sync[0];

    // ------------------------------------------------------------------
    // Serial clock edges
    // ------------------------------------------------------------------
    logic sclk_d_reg;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;

    // ------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] shift_in_reg;
    logic [3:0] bit_cnt_reg;
    logic [WORD_W-1:0] word_in;
    logic word_done;

    assign word_in = {shift_in_reg[WORD_W-2:0], sdin_s};
    assign word_done = sclk_rise && (bit_cnt_reg == LAST_BIT_CNT);

    always_ff @(posedge i_clk) begin
        if (!i_nrst || cs_n_s) begin
            shift_in_reg <= WORD_ZERO;
            bit_cnt_reg <= BIT_CNT_ZERO;
        end else if (sclk_rise) begin
            shift_in_reg <= word_in;
            bit_cnt_reg <= 4'(bit_cnt_reg + 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Host port sequencing
    // ------------------------------------------------------------------
    vpc_host_state_e state_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic autoinc_reg;
    logic wr_strobe;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_reg <= VPC_HP_IDLE;
            addr_reg <= '0;
            autoinc_reg <= 1'b0;
        end else if (cs_n_s) begin
            state_reg <= VPC_HP_IDLE;
        end else begin
            case (state_reg)
                VPC_HP_IDLE: begin
                    state_reg <= VPC_HP_CMD;
                end
                VPC_HP_CMD: begin
                    if (word_done) begin
                        addr_reg <= word_in[ADDR_W-1:0];
                        autoinc_reg <= word_in[CMD_AUTOINC_BIT];
                        // High selects a read, low a write
                        state_reg <= word_in[CMD_RW_BIT] ? VPC_HP_RDATA : VPC_HP_WDATA;
                    end
                end
                VPC_HP_WDATA: begin
                    if (word_done) begin
                        if (autoinc_reg) begin
                            addr_reg <= next_addr(addr_reg);
                        end else begin
                            state_reg <= VPC_HP_CMD;
                        end
                    end
                end
                VPC_HP_RDATA: begin
                    if (word_done) begin
                        if (autoinc_reg) begin
                            addr_reg <= next_addr(addr_reg);
                        end else begin
                            state_reg <= VPC_HP_CMD;
                        end
                    end
                end
                default: begin
                    state_reg <= VPC_HP_IDLE;
                end
            endcase
        end
    end

    assign wr_strobe = (state_reg == VPC_HP_WDATA) && word_done;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] ctrl_one_reg;
    logic [WORD_W-1:0] ctrl_two_reg;

    // Reserved bits are never stored, so they read back as zero
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ctrl_one_reg <= RST_IO_PROC_ONE;
            ctrl_two_reg <= RST_IO_PROC_TWO;
        end else if (wr_strobe) begin
            if (addr_reg == ADDR_IO_PROC_ONE) begin
                ctrl_one_reg <= word_in & reg_mask(addr_reg);
            end else if (addr_reg == ADDR_IO_PROC_TWO) begin
                ctrl_two_reg <= word_in & reg_mask(addr_reg);
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-back shifter
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] shift_out_reg;
    logic load_pending_reg;

    always_comb begin
        rd_word = WORD_ZERO;
        if (addr_reg == ADDR_IO_PROC_ONE) begin
            rd_word = ctrl_one_reg & reg_mask(addr_reg);
        end else if (addr_reg == ADDR_IO_PROC_TWO) begin
            rd_word = ctrl_two_reg & reg_mask(addr_reg);
        end
    end

    // The word loads on the falling edge that ends the previous word,
    // so the MSB is ready before the host samples the first read bit.
    always_ff @(posedge i_clk) begin
        if (!i_nrst || cs_n_s) begin
            load_pending_reg <= 1'b0;
        end else if (word_done && (state_reg == VPC_HP_CMD)) begin
            load_pending_reg <= word_in[CMD_RW_BIT];
        end else if (word_done && (state_reg == VPC_HP_RDATA)) begin
            load_pending_reg <= autoinc_reg;
        end else if (sclk_fall) begin
            load_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst || cs_n_s) begin
            shift_out_reg <= WORD_ZERO;
        end else if (sclk_fall) begin
            if (load_pending_reg) begin
                shift_out_reg <= rd_word;
            end else begin
                shift_out_reg <= {shift_out_reg[WORD_W-2:0], 1'b0};
            end
        end
    end

    // Writes echo the input so a daisy chain still sees the words;
    // the echo is three core cycles late, a limit of sampled pins.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_sdout <= 1'b0;
            o_sdout_oe_n <= 1'b1;
        end else begin
            o_sdout <= (state_reg == VPC_HP_RDATA) ? shift_out_reg[WORD_W-1] : sdin_s;
            o_sdout_oe_n <= cs_n_s;
        end
    end

    // ------------------------------------------------------------------
    // Timing reference selection
    // ------------------------------------------------------------------
    logic timing_861_eff;

    assign timing_861_eff = ctrl_one_reg[B1_TIMING_PIN_OVERRIDE]
        ? ctrl_one_reg[B1_TIMING_FORMAT]
        : fmt_pin_s;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_timing_861 <= 1'b0;
            o_h <= 1'b0;
        end else begin
            o_timing_861 <= timing_861_eff;
            if (timing_861_eff) begin
                o_h <= i_hsync_861;
            end else if (ctrl_one_reg[B1_H_BLANK_STYLE]) begin
                o_h <= i_trs_h_flag;
            end else begin
                o_h <= i_line_blank;
            end
        end
    end

    // ------------------------------------------------------------------
    // Processing enables
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_err_flag_update_en <= 1'b1;
            o_err_check_insert_en <= 1'b1;
            o_aux_extract_en <= 1'b1;
            o_timing_word_remap_en_s1 <= 1'b1;
            o_timing_word_remap_en_s2 <= 1'b1;
            o_bad_word_remap_en_s1 <= 1'b1;
            o_aux_sum_insert_en_s1 <= 1'b1;
            o_line_check_insert_en_s1 <= 1'b1;
            o_line_number_insert_en_s1 <= 1'b1;
            o_timing_word_insert_en_s1 <= 1'b1;
            o_payload_id_regen_en <= 1'b0;
            o_level_convert_en <= 1'b0;
        end else begin
            o_err_flag_update_en <= ~ctrl_one_reg[B1_ERR_FLAG_UPDATE_OFF];
            o_err_check_insert_en <= ~ctrl_one_reg[B1_ERR_CHECK_INSERT_OFF];
            o_aux_extract_en <= ~ctrl_one_reg[B1_AUX_EXTRACT_OFF];
            o_timing_word_remap_en_s1 <= ~ctrl_one_reg[B1_TIMING_WORD_REMAP_OFF_S1];
            o_timing_word_remap_en_s2 <= ~ctrl_two_reg[B2_TIMING_WORD_REMAP_OFF_S2];
            o_bad_word_remap_en_s1 <= ~ctrl_one_reg[B1_BAD_WORD_REMAP_OFF_S1];
            o_aux_sum_insert_en_s1 <= ~ctrl_one_reg[B1_AUX_SUM_INSERT_OFF_S1];
            o_line_check_insert_en_s1 <= ~ctrl_one_reg[B1_LINE_CHECK_INSERT_OFF_S1];
            o_line_number_insert_en_s1 <= ~ctrl_one_reg[B1_LINE_NUMBER_INSERT_OFF_S1];
            o_timing_word_insert_en_s1 <= ~ctrl_one_reg[B1_TIMING_WORD_INSERT_OFF_S1];
            // Regeneration and conversion only apply to Level B input
            o_payload_id_regen_en <= i_level_b & ~ctrl_two_reg[B2_PAYLOAD_ID_REGEN_OFF];
            o_level_convert_en <= i_level_b & ~ctrl_two_reg[B2_LEVEL_CONVERT_OFF];
        end
    end

    // ------------------------------------------------------------------
    // Parallel output placement
    // ------------------------------------------------------------------
    vpc_out_mux #(
        .SW(SW)
    ) u_out_mux (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_s1(i_stream_one),
        .i_s2(i_stream_two),
        .i_swap(ctrl_two_reg[B2_STREAM_SWAP]),
        .i_ddr_mode(i_ddr_mode),
        .o_dout(o_dout),
        .o_second_word(o_second_word)
    );
endmodule

/* tb/vpc_ctrl_regs_chk.sv */
// Purpose: Port-level checks for the video processing control registers
// Assumes: One i_clk domain, synchronous active-low reset
// Notes: Chip-select passes two sync stages plus one register
`timescale 1ns/10ps
module vpc_ctrl_regs_chk #(
    parameter int SW = 10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic o_sdout_oe_n,
    input wire logic i_level_b,
    input wire logic i_line_blank,
    input wire logic i_trs_h_flag,
    input wire logic i_hsync_861,
    input wire logic i_ddr_mode,
    input wire logic [SW-1:0] i_stream_one,
    input wire logic [SW-1:0] i_stream_two,
    input wire logic o_h,
    input wire logic o_timing_861,
    input wire logic o_err_flag_update_en,
    input wire logic o_err_check_insert_en,
    input wire logic o_aux_extract_en,
    input wire logic o_timing_word_remap_en_s1,
    input wire logic o_payload_id_regen_en,
    input wire logic o_level_convert_en,
    input wire logic [2*SW-1:0] o_dout,
    input wire logic o_second_word
);
    // ----------------------------------------------------------------
    // Defaults
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    logic [3:0] ens;
    assign ens = {o_err_flag_update_en, o_err_check_insert_en, o_aux_extract_en,
                  o_timing_word_remap_en_s1};
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_oe_follows_cs: assert property (!i_cs_n [*5] |-> !o_sdout_oe_n)
        else $error("sdout enable inactive while selected");
    a_reset_defaults: assert property ($rose(i_nrst) |-> ens == 4'hf && !o_level_convert_en
        && !o_payload_id_regen_en && o_dout == '0 && !o_second_word)
        else $error("outputs not at reset values");
    a_wide_order: assert property (!i_ddr_mode |=> !o_second_word
        && (o_dout == {$past(i_stream_one), $past(i_stream_two)}
        || o_dout == {$past(i_stream_two), $past(i_stream_one)}))
        else $error("20-bit output not a stream pair");
    a_ddr_upper_zero: assert property (i_ddr_mode |=> o_dout[2*SW-1:SW] == '0)
        else $error("DDR upper bits not zero");
    a_ddr_alternate: assert property (i_ddr_mode && $past(i_ddr_mode)
        |=> o_second_word != $past(o_second_word))
        else $error("DDR word phase did not alternate");
    a_ddr_lead_first: assert property ($rose(i_ddr_mode) |=> !o_second_word)
        else $error("DDR did not start on leading word");
    a_h_from_sync: assert property (o_timing_861 |-> o_h == $past(i_hsync_861))
        else $error("H not following CEA-861 sync");
    a_h_low_outside: assert property (!o_timing_861 && !$past(i_line_blank)
        && !$past(i_trs_h_flag) |-> !o_h)
        else $error("H high with no blanking source");
    a_regen_level_b: assert property (o_payload_id_regen_en |-> $past(i_level_b))
        else $error("payload regeneration without Level B");
    a_convert_level_b: assert property (o_level_convert_en |-> $past(i_level_b))
        else $error("conversion without Level B");
    c_ddr_second: cover property (i_ddr_mode && o_second_word);
    c_sync_h: cover property (o_timing_861 && o_h);
    c_convert: cover property (o_level_convert_en);
endmodule

bind vpc_ctrl_regs vpc_ctrl_regs_chk #(.SW(SW)) u_chk (.i_clk, .i_nrst, .i_cs_n, .o_sdout_oe_n,
    .i_level_b, .i_line_blank, .i_trs_h_flag, .i_hsync_861, .i_ddr_mode, .i_stream_one,
    .i_stream_two, .o_h, .o_timing_861, .o_err_flag_update_en, .o_err_check_insert_en,
    .o_aux_extract_en, .o_timing_word_remap_en_s1, .o_payload_id_regen_en,
    .o_level_convert_en, .o_dout, .o_second_word);

/* tb/tb_top.sv */
// Purpose: Register and output checks through the host serial port
// Assumes: Serial clock phases of six core cycles, far above the minimum
// Notes: Inputs change on the falling core clock edge only
`timescale 1ns/10ps
module tb_top;
    import vpc_pkg::*;
    logic i_clk, i_nrst, i_cs_n, i_sclk, i_sdin, i_timing_format_pin, i_level_b;
    logic i_line_blank, i_trs_h_flag, i_hsync_861, i_ddr_mode;
    logic [9:0] i_stream_one, i_stream_two;
    logic o_sdout, o_sdout_oe_n, o_h, o_timing_861, o_err_flag_update_en;
    logic o_err_check_insert_en, o_aux_extract_en, o_timing_word_remap_en_s1;
    logic o_timing_word_remap_en_s2, o_bad_word_remap_en_s1, o_aux_sum_insert_en_s1;
    logic o_line_check_insert_en_s1, o_line_number_insert_en_s1, o_timing_word_insert_en_s1;
    logic o_payload_id_regen_en, o_level_convert_en, o_second_word;
    logic [19:0] o_dout;
    logic [8:0] ens;
    int n_mismatch = 0;
    int comparisons = 0;
    int pos[9] = '{12, 11, 9, 14, 4, 3, 2, 1, 0};

    vpc_ctrl_regs #(.SW(10)) u_dut (.i_clk, .i_nrst, .i_cs_n, .i_sclk, .i_sdin, .o_sdout,
        .o_sdout_oe_n, .i_timing_format_pin, .i_level_b, .i_line_blank, .i_trs_h_flag,
        .i_hsync_861, .i_ddr_mode, .i_stream_one, .i_stream_two, .o_h, .o_timing_861,
        .o_err_flag_update_en, .o_err_check_insert_en, .o_aux_extract_en,
        .o_timing_word_remap_en_s1, .o_timing_word_remap_en_s2, .o_bad_word_remap_en_s1,
        .o_aux_sum_insert_en_s1, .o_line_check_insert_en_s1, .o_line_number_insert_en_s1,
        .o_timing_word_insert_en_s1, .o_payload_id_regen_en, .o_level_convert_en, .o_dout,
        .o_second_word);

    assign ens = {o_err_flag_update_en, o_err_check_insert_en, o_aux_extract_en,
                  o_timing_word_remap_en_s1, o_bad_word_remap_en_s1, o_aux_sum_insert_en_s1,
                  o_line_check_insert_en_s1, o_line_number_insert_en_s1,
                  o_timing_word_insert_en_s1};

    always #50 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Read data is sampled just before the rising edge, as a host does;
    // after the last rise the output falls back to the echo.
    task automatic xfer(input logic [15:0] w_out, output logic [15:0] w_in);
        for (int i = 15; i >= 0; i--) begin
            i_sclk = 1'b0;
            i_sdin = w_out[i];
            repeat (6) @(negedge i_clk);
            w_in[i] = o_sdout;
            i_sclk = 1'b1;
            repeat (6) @(negedge i_clk);
        end
    endtask

    task automatic host(input logic rd, input logic [11:0] addr, input logic [15:0] wdat,
                        output logic [15:0] rdat);
        logic [15:0] junk;
        i_cs_n = 1'b0;
        repeat (6) @(negedge i_clk);
        xfer({rd, 3'h0, addr}, junk);
        xfer(wdat, rdat);
        i_sclk = 1'b0;
        repeat (6) @(negedge i_clk);
        i_cs_n = 1'b1;
        repeat (8) @(negedge i_clk);
    endtask

    task automatic settle();
        repeat (4) @(negedge i_clk);
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] rd;
        logic [8:0] e9;
        {i_clk, i_nrst, i_sclk, i_sdin, i_timing_format_pin, i_trs_h_flag} = 6'h00;
        {i_cs_n, i_level_b, i_line_blank, i_hsync_861, i_ddr_mode} = 5'h1c;
        i_stream_one = 10'h155;
        i_stream_two = 10'h2a3;
        repeat (5) @(negedge i_clk);
        i_nrst = 1'b1;
        settle();
        check(ens, 9'h1ff);
        check({o_payload_id_regen_en, o_level_convert_en}, 2'h2);
        host(1'b1, ADDR_IO_PROC_ONE, 16'h0000, rd);
        check(rd, 16'h0000);
        host(1'b1, ADDR_IO_PROC_TWO, 16'h0000, rd);
        check(rd, 16'h0100);
        host(1'b0, ADDR_IO_PROC_ONE, 16'hffff, rd);
        host(1'b1, ADDR_IO_PROC_ONE, 16'h0000, rd);
        check(rd, 16'h5edf);
        check(ens, 9'h000);
        for (int i = 0; i < 9; i++) begin
            host(1'b0, ADDR_IO_PROC_ONE, 16'h0001 << pos[i], rd);
            e9 = ~(9'h100 >> i);
            check(ens, e9);
        end
        host(1'b0, ADDR_IO_PROC_TWO, 16'hffff, rd);
        host(1'b1, ADDR_IO_PROC_TWO, 16'h0000, rd);
        check(rd, 16'h1700);
        check({o_timing_word_remap_en_s2, o_payload_id_regen_en, o_level_convert_en}, 3'h0);
        // Clearing the register re-enables regeneration, conversion and the stream two remap
        host(1'b0, ADDR_IO_PROC_TWO, 16'h0000, rd);
        check({o_timing_word_remap_en_s2, o_payload_id_regen_en, o_level_convert_en}, 3'h7);
        i_level_b = 1'b0;
        settle();
        check({o_payload_id_regen_en, o_level_convert_en}, 2'h0);
        host(1'b0, 12'h002, 16'hffff, rd);
        host(1'b1, 12'h002, 16'h0000, rd);
        check(rd, 16'h0000);
        host(1'b0, ADDR_IO_PROC_ONE, 16'h0000, rd);
        check({o_timing_861, o_h}, 2'h1);
        i_line_blank = 1'b0;
        settle();
        check({o_timing_861, o_h}, 2'h0);
        i_line_blank = 1'b1;
        host(1'b0, ADDR_IO_PROC_ONE, 16'h0400, rd);
        check({o_timing_861, o_h}, 2'h0);
        i_trs_h_flag = 1'b1;
        settle();
        check({o_timing_861, o_h}, 2'h1);
        i_timing_format_pin = 1'b1;
        settle();
        check({o_timing_861, o_h}, 2'h2);
        host(1'b0, ADDR_IO_PROC_ONE, 16'h0480, rd);
        check({o_timing_861, o_h}, 2'h1);
        i_hsync_861 = 1'b1;
        host(1'b0, ADDR_IO_PROC_ONE, 16'h04c0, rd);
        check({o_timing_861, o_h}, 2'h3);
        check(o_dout, {i_stream_one, i_stream_two});
        host(1'b0, ADDR_IO_PROC_TWO, 16'h0200, rd);
        check(o_dout, {i_stream_two, i_stream_one});
        for (int k = 0; k < 2; k++) begin
            i_ddr_mode = 1'b1;
            @(negedge i_clk);
            check({o_second_word, o_dout}, {k == 0 ? i_stream_one : i_stream_two});
            @(negedge i_clk);
            check({o_second_word, o_dout}, {11'h400, k == 0 ? i_stream_two : i_stream_one});
            i_ddr_mode = 1'b0;
            host(1'b0, ADDR_IO_PROC_TWO, 16'h0000, rd);
        end
        end_sim();
    end

    initial begin
        repeat (40000) @(posedge i_clk);
        n_mismatch++;
        end_sim();
    end
endmodule
